// file: cacm_defs.svh
// Purpose: Register offsets, field positions and reset values for the
//          counter array compare module.
// Assumes: Avalon-MM word addressing, one register per 32-bit word.
// Notes:   Offsets are word indexes; the byte address is four times it.
`ifndef CACM_DEFS_SVH
`define CACM_DEFS_SVH

// Register word addresses (address port is a word index)
`define CACM_ADDR_W 3
`define CACM_OFF_CTRL 3'h0
`define CACM_OFF_MODE 3'h1
`define CACM_OFF_CMPL 3'h2
`define CACM_OFF_CMPH 3'h3
`define CACM_OFF_CNTL 3'h4
`define CACM_OFF_CNTH 3'h5

// Field positions in array_control_reg
`define CACM_CTRL_FLAG 0
`define CACM_CTRL_RUN 6
// Field positions in module_mode_reg
`define CACM_MODE_FLAGIE 0
`define CACM_MODE_MATCH 3
`define CACM_MODE_CMPEN 6

// Reset values
`define CACM_RST_BYTE 8'h00
`define CACM_RST_CNT 16'h0000
// Unmapped reads return this word
`define CACM_UNMAPPED 32'h0000_0000

`endif

// file: cacm_pkg.sv
// Purpose: Types shared by the compare module files.
// Assumes: Constants live in cacm_defs.svh.
// Notes:   Holds types only.
package cacm_pkg;
    // Bus slave phase
    typedef enum logic [0:0] {CACM_IDLE, CACM_ACK} cacm_bus_t;
    // One register byte
    typedef logic [7:0] cacm_byte_t;
endpackage

// file: cacm_match.sv
// Purpose: Equality detector for counter and compare value.
// Assumes: Inputs are on sys_clk_i; no crossing needed.
// Notes:   Emits one pulse when equality begins, not while it lasts.
`timescale 1ns/100ps
`include "cacm_defs.svh"
module cacm_match #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk_i, // System clock
    input wire logic nrst_i, // Synchronous reset, low
    input wire logic armed_i, // Compare enabled in timer mode
    input wire logic [WIDTH-1:0] count_i, // Array counter value
    input wire logic [WIDTH-1:0] value_i, // Compare value
    output logic hit_o // One-cycle match pulse
);
    import cacm_pkg::*;

    // Width check at elaboration
    if (WIDTH < 2) begin : g_chk
        $error("cacm_match: WIDTH too small");
    end

    // Equality of counter and compare value
    wire logic equal = armed_i && (count_i == value_i);
    // Previous equality, so a long match fires once
    logic equal_q;

    // Edge of equality becomes a hit
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            equal_q <= 1'b0;
            hit_o <= 1'b0;
        end
        else
        begin
            equal_q <= equal;
            hit_o <= equal && !equal_q;
        end
    end
endmodule // cacm_match

// file: cacm_top.sv
// Purpose: One counter array module in software timer (compare) mode,
//          with the shared counter and an Avalon-MM register slave.
// Assumes: 20 MHz sys_clk_i; software is the only bus master.
// Notes:   Read data is answered one cycle after the request.
//          Writes land at the edge that takes the request; the answer
//          cycle that follows only lets the master go.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "cacm_defs.svh"
module cacm_top #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_i, // System clock, 20 MHz
    input wire logic nrst_i, // Synchronous reset, low
    input wire logic [`CACM_ADDR_W-1:0] avs_address, // Word address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall until answer
    output logic irq_o, // Module interrupt request
    output logic match_flag_o // Match flag level
);
    import cacm_pkg::*;

    // Only the 16-bit layout has byte registers for it
    if (CNT_W != 16) begin : g_chk
        $error("cacm_top: CNT_W must be 16");
    end

    // Slave state and registers
    cacm_bus_t bus_state; // Idle or answering
    logic run; // Counter run bit
    logic match_flag; // Sticky match flag
    logic flag_irq_en; // Interrupt enable for flag
    logic match_en; // match_flag_enable
    logic compare_enable; // Compare enable
    cacm_byte_t compare_low_byte; // Compare value low
    cacm_byte_t compare_high_byte; // Compare value high
    logic [CNT_W-1:0] counter; // Shared array counter
    logic hit; // Match pulse from detector

    // Request accepted in the idle cycle, one cycle before the slave answers
    wire logic req = (avs_read || avs_write) && (bus_state == CACM_IDLE);
    wire logic wr = avs_write && (bus_state == CACM_IDLE);
    wire logic lane0 = avs_byteenable[0];
    wire logic wr_ctrl = wr && lane0 && (avs_address == `CACM_OFF_CTRL);
    wire logic wr_mode = wr && lane0 && (avs_address == `CACM_OFF_MODE);
    wire logic wr_cmpl = wr && lane0 && (avs_address == `CACM_OFF_CMPL);
    wire logic wr_cmph = wr && lane0 && (avs_address == `CACM_OFF_CMPH);
    wire logic wr_cntl = wr && lane0 && (avs_address == `CACM_OFF_CNTL);
    wire logic wr_cnth = wr && lane0 && (avs_address == `CACM_OFF_CNTH);
    wire cacm_byte_t wbyte = avs_writedata[7:0];

    // Software timer mode needs both enables
    // mode qualification
    wire logic timer_mode = compare_enable && match_en;

    // Status and mode bytes as software sees them
    wire cacm_byte_t ctrl_byte = {1'b0, run, 5'h00, match_flag};
    wire cacm_byte_t mode_byte = {1'b0, compare_enable, 2'h0, match_en,
                                  2'h0, flag_irq_en};

    // Read mux; unmapped words read as zero
    // Reads have no side effects, so a poll never loses the flag
    wire cacm_byte_t rd_byte =
        (avs_address == `CACM_OFF_CTRL) ? ctrl_byte :
        (avs_address == `CACM_OFF_MODE) ? mode_byte :
        (avs_address == `CACM_OFF_CMPL) ? compare_low_byte :
        (avs_address == `CACM_OFF_CMPH) ? compare_high_byte :
        (avs_address == `CACM_OFF_CNTL) ? counter[7:0] :
        (avs_address == `CACM_OFF_CNTH) ? counter[15:8] :
        `CACM_RST_BYTE;

    // Flag set wins over a software clear in the same cycle
    // set on hit
    wire logic next_match_flag = hit ? 1'b1 :
        (wr_ctrl ? wbyte[`CACM_CTRL_FLAG] : match_flag);

    // Compare enable side effects of byte writes
    // low write clears
    wire logic next_compare_enable = wr_cmph ? 1'b1 :
        wr_cmpl ? 1'b0 :
        wr_mode ? wbyte[`CACM_MODE_CMPEN] : compare_enable;

    // Bus handshake: waitrequest high until the answer cycle
    // Fixed single wait keeps the master simple; no deeper pipeline
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            bus_state <= CACM_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `CACM_UNMAPPED;
        end
        else if (req)
        begin
            bus_state <= CACM_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= {24'h000000, rd_byte};
        end
        else
        begin
            // Back to idle after the one answer cycle
            bus_state <= CACM_IDLE;
            avs_waitrequest <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            run <= 1'b0;
            flag_irq_en <= 1'b0;
            match_en <= 1'b0;
            compare_enable <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                run <= wbyte[`CACM_CTRL_RUN];
            end
            if (wr_mode)
            begin
                flag_irq_en <= wbyte[`CACM_MODE_FLAGIE];
                match_en <= wbyte[`CACM_MODE_MATCH];
            end
            compare_enable <= next_compare_enable;
        end
    end

    // Compare bytes; low first keeps compare off until the pair is whole
    // write order relied on
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            compare_low_byte <= `CACM_RST_BYTE;
            compare_high_byte <= `CACM_RST_BYTE;
        end
        else
        begin
            if (wr_cmpl)
            begin
                compare_low_byte <= wbyte;
            end
            if (wr_cmph)
            begin
                compare_high_byte <= wbyte;
            end
        end
    end

    // Free-running array counter, software loadable per byte
    // A byte load wins over counting, so a load while running is exact
    // The cycle of a load skips one increment of the whole counter
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            counter <= `CACM_RST_CNT;
        end
        else if (wr_cntl)
        begin
            counter[7:0] <= wbyte;
        end
        else if (wr_cnth)
        begin
            counter[15:8] <= wbyte;
        end
        else if (run)
        begin
            counter <= counter + 16'h0001;
        end
    end

    // Equality detector, one pulse per match
    // Edge detection lives there so a stopped counter fires only once
    // continuous compare
    // gated by enable, once per match
    cacm_match #(
        .WIDTH(CNT_W)
    ) u_match (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .armed_i(timer_mode),
        .count_i(counter),
        .value_i({compare_high_byte, compare_low_byte}),
        .hit_o(hit)
    );

    // Flag and interrupt outputs, all registered
    // Port copy of the flag is its own flop so the output is registered
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            match_flag <= 1'b0;
            match_flag_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            match_flag <= next_match_flag;
            match_flag_o <= next_match_flag;
            irq_o <= next_match_flag && flag_irq_en;
        end
    end
endmodule // cacm_top

// file: cacm_top_asserts.sv
// Purpose: Port checks for cacm_top.
// Assumes: One clock, reset low and synchronous.
// Notes: Enables are shadowed from accepted bus writes.
`timescale 1ns/100ps
`include "cacm_defs.svh"
module cacm_chk #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_i, // Clock
    input wire logic nrst_i, // Reset
    input wire logic [`CACM_ADDR_W-1:0] avs_address, // Address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Data in
    input wire logic [3:0] avs_byteenable, // Lanes
    input wire logic [31:0] avs_readdata, // Data out
    input wire logic avs_waitrequest, // Stall
    input wire logic irq_o, // Request
    input wire logic match_flag_o // Flag
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // Write accepted at this edge
    wire logic wr_tk = avs_write && avs_waitrequest && avs_byteenable[0];
    wire logic [7:0] wd = avs_writedata[7:0];
    logic ie; // Interrupt enable shadow
    logic me; // Match enable shadow
    logic ce; // Compare enable shadow
    // Shadow of the timer mode qualification
    wire logic arm = me && ce;
    logic [2:0] age; // Cycles since a flag clear
    // Shadows follow writes; low/high bytes move ce
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            ie <= 1'b0;
            me <= 1'b0;
            ce <= 1'b0;
            age <= 3'h7;
        end
        else
        begin
            if (wr_tk && avs_address == `CACM_OFF_MODE)
            begin
                ie <= wd[0];
                me <= wd[3];
                ce <= wd[6];
            end
            if (wr_tk && avs_address == `CACM_OFF_CMPL)
                ce <= 1'b0;
            if (wr_tk && avs_address == `CACM_OFF_CMPH)
                ce <= 1'b1;
            if (wr_tk && avs_address == `CACM_OFF_CTRL && !wd[0])
                age <= 3'h0;
            else if (age != 3'h7)
                age <= age + 3'h1;
        end
    end
    sequence take_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    bus_answer_a: assert property (take_s |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    idle_wait_a: assert property
        (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    unmapped_zero_a: assert property
        (take_s and avs_read && avs_address > 3'h5 |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    irq_gate_a: assert property
        (irq_o |-> match_flag_o && (ie || $past(ie)))
        else $error("irq without flag and enable");
    irq_raise_a: assert property ((match_flag_o && ie) [*3] |-> irq_o)
        else $error("irq missing while flag enabled");
    flag_hold_a: assert property ($fell(match_flag_o) |-> age < 3'h4)
        else $error("flag dropped without clear write");
    arm_gate_a: assert property ($rose(match_flag_o) |-> arm
        || $past(arm) || $past(arm, 2) || $past(arm, 3))
        else $error("flag set while compare disabled");
endmodule // cacm_chk
bind cacm_top cacm_chk #(.CNT_W(CNT_W)) chk_u (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_o(irq_o),
    .match_flag_o(match_flag_o));

// file: counter_array_compare_mode_tb.sv
// Purpose: Register-level test of cacm_top.
// Assumes: 20 MHz clock; bench is the only bus master.
// Notes: Counter is loaded over the bus so matches land early.
`timescale 1ns/100ps
`include "cacm_defs.svh"
module counter_array_compare_mode_tb;
    import cacm_pkg::*;
    logic sys_clk_i = 1'b0; // Clock
    logic nrst_i = 1'b0; // Reset
    logic [`CACM_ADDR_W-1:0] adr = 3'h0; // Address
    logic rd = 1'b0; // Read
    logic wr = 1'b0; // Write
    logic [31:0] wd = 32'h0; // Data in
    logic [31:0] rdat; // Data out
    logic wreq; // Stall
    logic irq; // Request
    logic flg; // Flag
    logic [31:0] q; // Last read
    logic f; // Scan result
    int fails = 0;
    int checks_done = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    cacm_top #(.CNT_W(16)) dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .irq_o(irq), .match_flag_o(flg));
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus cycle; held until waitrequest is seen low
    task xfer(input logic w, input logic [2:0] a, input cacm_byte_t d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        adr <= a;
        wd <= {24'h0, d};
        rd <= !w;
        wr <= w;
        @(posedge sys_clk_i);
        while (wreq !== 1'b0 && n < 20)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20)
        begin
            fails++;
            summarize();
        end
    endtask
    task rchk(input string nm, input logic [2:0] a, input logic [31:0] e);
        xfer(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    // Watch the flag over a window wide enough to pass the match
    task scan(output logic s);
        s = 1'b0;
        repeat (60)
        begin
            @(posedge sys_clk_i);
            if (flg === 1'b1)
                s = 1'b1;
        end
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        // Reset values; places 6 and 7 are unmapped
        for (int i = 0; i < 8; i++)
            rchk("reset", i[2:0], 32'h0);
        $display("test reset done");
        xfer(1'b1, `CACM_OFF_CNTL, 8'h01);
        xfer(1'b1, `CACM_OFF_MODE, 8'h49);
        xfer(1'b1, `CACM_OFF_CMPL, 8'h10);
        rchk("mode", `CACM_OFF_MODE, 32'h09);
        xfer(1'b1, `CACM_OFF_CMPH, 8'h00);
        rchk("mode", `CACM_OFF_MODE, 32'h49);
        rchk("cmp low", `CACM_OFF_CMPL, 32'h10);
        rchk("cmp high", `CACM_OFF_CMPH, 32'h00);
        xfer(1'b1, `CACM_OFF_CTRL, 8'h40);
        scan(f);
        chk("flag", 32'h1, {31'h0, f});
        chk("irq", 32'h1, {31'h0, irq});
        rchk("ctrl", `CACM_OFF_CTRL, 32'h41);
        xfer(1'b1, `CACM_OFF_CTRL, 8'h40);
        repeat (2) @(posedge sys_clk_i);
        chk("flag", 32'h0, {31'h0, flg});
        chk("irq", 32'h0, {31'h0, irq});
        $display("test match done");
        xfer(1'b1, `CACM_OFF_CTRL, 8'h00);
        xfer(1'b1, `CACM_OFF_CNTL, 8'h28);
        xfer(1'b1, `CACM_OFF_CMPL, 8'h30);
        xfer(1'b1, `CACM_OFF_CTRL, 8'h40);
        scan(f);
        chk("flag", 32'h0, {31'h0, f});
        xfer(1'b1, `CACM_OFF_CTRL, 8'h00);
        xfer(1'b1, `CACM_OFF_CNTL, 8'h28);
        xfer(1'b1, `CACM_OFF_MODE, 8'h08);
        xfer(1'b1, `CACM_OFF_CMPH, 8'h00);
        rchk("mode", `CACM_OFF_MODE, 32'h48);
        xfer(1'b1, `CACM_OFF_CTRL, 8'h40);
        scan(f);
        chk("flag", 32'h1, {31'h0, f});
        chk("irq", 32'h0, {31'h0, irq});
        // Compare on but match enable off: no flag
        xfer(1'b1, `CACM_OFF_CTRL, 8'h00);
        xfer(1'b1, `CACM_OFF_CNTL, 8'h28);
        xfer(1'b1, `CACM_OFF_MODE, 8'h40);
        xfer(1'b1, `CACM_OFF_CTRL, 8'h40);
        scan(f);
        chk("flag", 32'h0, {31'h0, f});
        $display("test gate done");
        // Held equality sets the flag once only
        xfer(1'b1, `CACM_OFF_CTRL, 8'h00);
        xfer(1'b1, `CACM_OFF_CNTL, 8'h30);
        xfer(1'b1, `CACM_OFF_CNTH, 8'h00);
        xfer(1'b1, `CACM_OFF_MODE, 8'h48);
        scan(f);
        chk("flag", 32'h1, {31'h0, f});
        xfer(1'b1, `CACM_OFF_CTRL, 8'h00);
        scan(f);
        chk("flag", 32'h0, {31'h0, f});
        $display("test hold done");
        summarize();
    end
endmodule // counter_array_compare_mode_tb
